// ==== hdl/dpe_map.svh ====
// register offsets, reset values, ranges and timing counts of the power element
`ifndef DPE_MAP_SVH
`define DPE_MAP_SVH

// register byte offsets
`define DPE_ADDR_CTRL 12'h000
`define DPE_ADDR_START_POWER 12'h004
`define DPE_ADDR_DIR_ANGLE 12'h008
`define DPE_ADDR_DELAY 12'h00c
`define DPE_ADDR_STATUS 12'h010

// control fields and reset
`define DPE_CTRL_ENABLE_BIT 0
`define DPE_CTRL_START_ONLY_BIT 1
`define DPE_CTRL_RESET 2'h0

// start power in tenths of a percent
`define DPE_START_POWER_RESET 11'h064
`define DPE_START_POWER_MIN 11'h00a
`define DPE_START_POWER_MAX 11'h7d0

// direction angle in whole degrees, signed
`define DPE_ANGLE_RESET 9'sh000
`define DPE_ANGLE_MIN 9'sh14d
`define DPE_ANGLE_MAX 9'sh0b4
`define DPE_ANGLE_QUARTER 9'sh05a
`define DPE_ANGLE_NEG_QUARTER 9'sh1a6
`define DPE_HALF_TURN_Q8 18'sh0b400

// trip delay in milliseconds
`define DPE_DELAY_RESET 16'h00c8
`define DPE_DELAY_MIN 16'h00c8
`define DPE_DELAY_MAX 16'hea60

// scaling: 1.0 per unit is 2^14, three phases at nominal are 100 percent
`define DPE_UNIT_SHIFT 14
`define DPE_PHASES 3'sh3
`define DPE_TENTHS_PER_UNIT 12'sh3e8
`define DPE_CORDIC_GAIN_Q14 16'sh6965
`define DPE_CORDIC_ITER 4'hc

// drop-out threshold is 95 percent of pick-up
`define DPE_HYST_NUM 8'sh5f
`define DPE_HYST_DEN 8'sh64

// timer tick of one millisecond at a 5 ns clock
`define DPE_TICK_NS 32'h000f4240
`define DPE_CLK_NS 32'h00000005
`define DPE_TICK_CYCLES ((`DPE_TICK_NS + `DPE_CLK_NS - 32'h00000001) / `DPE_CLK_NS)

`endif

// ==== hdl/dpe_pkg.sv ====
// types shared by the directional power element
package dpe_pkg;

	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} dpe_phasor_t;

	typedef struct packed {
		logic signed [35:0] p;
		logic signed [35:0] q;
	} dpe_power_t;

	typedef enum logic [3:0] {
		DPE_IDLE = 4'h1,
		DPE_SUM = 4'h2,
		DPE_START = 4'h4,
		DPE_ROT = 4'h8
	} dpe_state_t;

endpackage

// ==== hdl/dpe_phase_power.sv ====
// complex power of one phase from its voltage and current phasors
`timescale 1ns/1ps
`default_nettype none
module dpe_phase_power (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// measurement
	input wire logic load,
	input wire dpe_pkg::dpe_phasor_t voltage,
	input wire dpe_pkg::dpe_phasor_t current,
	// result
	output dpe_pkg::dpe_power_t power
);

	logic signed [31:0] prod_rr;
	logic signed [31:0] prod_ii;
	logic signed [31:0] prod_ir;
	logic signed [31:0] prod_ri;
	dpe_pkg::dpe_power_t next_power;

	assign prod_rr = voltage.re * current.re;
	assign prod_ii = voltage.im * current.im;
	assign prod_ir = voltage.im * current.re;
	assign prod_ri = voltage.re * current.im;

	// s = v * conj(i)
	always_comb
	begin
		next_power = power;
		if (load)
		begin
			next_power.p = 36'(prod_rr) + 36'(prod_ii);
			next_power.q = 36'(prod_ir) - 36'(prod_ri);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			power <= '0;
		else
			power <= next_power;
	end

endmodule
`default_nettype wire

// ==== hdl/dpe_cordic.sv ====
// iterative rotation giving the component of (x, y) along a given angle
`timescale 1ns/1ps
`default_nettype none
`include "dpe_map.svh"
module dpe_cordic (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// request
	input wire logic start,
	input wire logic signed [35:0] x_in,
	input wire logic signed [35:0] y_in,
	input wire logic signed [8:0] angle,
	// result, scaled by the rotation gain
	output logic done,
	output logic signed [39:0] x_out
);

	logic signed [39:0] y;
	logic signed [17:0] z;
	logic [3:0] iter;
	logic busy;
	logic signed [39:0] next_x;
	logic signed [39:0] next_y;
	logic signed [17:0] next_z;
	logic [3:0] next_iter;
	logic next_busy;
	logic next_done;
	logic signed [17:0] z_load;

	// arctan(2^-i) in degrees, eight fraction bits
	function automatic logic signed [17:0] atan_q8(input logic [3:0] i);
		case (i)
			4'h0: atan_q8 = 18'sh02d00;
			4'h1: atan_q8 = 18'sh01a91;
			4'h2: atan_q8 = 18'sh00e09;
			4'h3: atan_q8 = 18'sh00720;
			4'h4: atan_q8 = 18'sh00394;
			4'h5: atan_q8 = 18'sh001ca;
			4'h6: atan_q8 = 18'sh000e5;
			4'h7: atan_q8 = 18'sh00073;
			4'h8: atan_q8 = 18'sh00039;
			4'h9: atan_q8 = 18'sh0001d;
			4'ha: atan_q8 = 18'sh0000e;
			4'hb: atan_q8 = 18'sh00007;
			default: atan_q8 = 18'sh00000;
		endcase
	endfunction

	assign z_load = 18'(angle) <<< 8;

	always_comb
	begin
		next_x = x_out;
		next_y = y;
		next_z = z;
		next_iter = iter;
		next_busy = busy;
		next_done = 1'b0;
		if (start)
		begin
			// bring the angle into -90..90 by a half turn
			next_iter = 4'h0;
			next_busy = 1'b1;
			if (angle > `DPE_ANGLE_QUARTER || angle < `DPE_ANGLE_NEG_QUARTER)
			begin
				next_x = -40'(x_in);
				next_y = -40'(y_in);
				next_z = (angle > `DPE_ANGLE_QUARTER) ? z_load - `DPE_HALF_TURN_Q8
					: z_load + `DPE_HALF_TURN_Q8;
			end
			else
			begin
				next_x = 40'(x_in);
				next_y = 40'(y_in);
				next_z = z_load;
			end
		end
		else if (busy)
		begin
			// rotate the vector by minus the angle
			if (z >= 18'sh00000)
			begin
				next_x = x_out + (y >>> iter);
				next_y = y - (x_out >>> iter);
				next_z = z - atan_q8(iter);
			end
			else
			begin
				next_x = x_out - (y >>> iter);
				next_y = y + (x_out >>> iter);
				next_z = z + atan_q8(iter);
			end
			next_iter = iter + 4'h1;
			if (iter == `DPE_CORDIC_ITER - 4'h1)
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			x_out <= '0;
			y <= '0;
			z <= '0;
			iter <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			x_out <= next_x;
			y <= next_y;
			z <= next_z;
			iter <= next_iter;
			busy <= next_busy;
			done <= next_done;
		end
	end

endmodule
`default_nettype wire

// ==== hdl/dpe_directional_power_high_element.sv ====
// directional over-power element: power, directional decision, gating, trip timer, apb
// Functional notes
// [RULE1] Three-phase active and reactive power are computed from the three voltage and current phasors.
// [RULE2] The characteristic is the line through the set point, normal to its direction.
// [RULE3] Operation needs the power point strictly beyond that line, angle inside -90..90 degrees.
// [RULE4] Once operated, the threshold drops to a hysteresis fraction of the start power.
// [RULE5] The start needs the directional decision with neither block input active.
// [RULE6] The general block input comes from outside logic and disables the whole function; code gates start and trip only, operate keeps updating.
// [RULE7] With start-only clear the delay runs from start and expiry trips; with it set, no trip.
// [RULE8] The trip delay spans 200 to 60000 ms in 1 ms steps, default 200 ms.
// [RULE9] The start power spans 1.0 to 200.0 percent in 0.1 percent steps, default 10.0.
// [RULE10] The direction angle spans -179 to 180 degrees in 1 degree steps, default 0.
// [RULE11] The enable setting defaults off, and while off neither start nor trip appears.
// [RULE12] The timer counts millisecond ticks and clears, with the trip, when the start drops.
`timescale 1ns/1ps
`default_nettype none
`include "dpe_map.svh"
module dpe_directional_power_high_element #(
	parameter int unsigned TICK_CYCLES = `DPE_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// phasors from the measurement stage
	input wire logic meas_valid,
	output logic meas_ready,
	input wire dpe_pkg::dpe_phasor_t phase_a_voltage,
	input wire dpe_pkg::dpe_phasor_t phase_b_voltage,
	input wire dpe_pkg::dpe_phasor_t phase_c_voltage,
	input wire dpe_pkg::dpe_phasor_t phase_a_current,
	input wire dpe_pkg::dpe_phasor_t phase_b_current,
	input wire dpe_pkg::dpe_phasor_t phase_c_current,
	// blocking inputs
	input wire logic general_block,
	input wire logic vt_supervision_inhibit,
	// element outputs
	output logic general_pickup,
	output logic general_trip_cmd
);

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] ctrl;
	logic [10:0] start_power;
	logic signed [8:0] dir_angle;
	logic [15:0] delay;
	logic [1:0] next_ctrl;
	logic [10:0] next_start_power;
	logic signed [8:0] next_dir_angle;
	logic [15:0] next_delay;
	logic [31:0] next_prdata;
	logic [31:0] merged;
	logic signed [8:0] angle_wr;
	logic addr_hit;
	logic wr_access;
	logic ctrl_enable;
	logic ctrl_start_only;

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		lane_merge = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				lane_merge[8*i +: 8] = wd[8*i +: 8];
		end
	endfunction

	assign ctrl_enable = ctrl[`DPE_CTRL_ENABLE_BIT];
	assign ctrl_start_only = ctrl[`DPE_CTRL_START_ONLY_BIT];
	assign pready = 1'b1;
	assign wr_access = psel && penable && pwrite;
	assign addr_hit = (paddr == `DPE_ADDR_CTRL) || (paddr == `DPE_ADDR_START_POWER)
		|| (paddr == `DPE_ADDR_DIR_ANGLE) || (paddr == `DPE_ADDR_DELAY)
		|| (paddr == `DPE_ADDR_STATUS);
	assign pslverr = psel && penable && (!addr_hit || (pwrite && paddr == `DPE_ADDR_STATUS));

	always_comb
	begin
		next_ctrl = ctrl;
		next_start_power = start_power;
		next_dir_angle = dir_angle;
		next_delay = delay;
		merged = 32'h00000000;
		angle_wr = dir_angle;
		if (wr_access)
		begin
			case (paddr)
				`DPE_ADDR_CTRL:
				begin
					merged = lane_merge({30'h00000000, ctrl}, pwdata, pstrb);
					next_ctrl = merged[1:0];
				end
				// [RULE9] start power clamp
				`DPE_ADDR_START_POWER:
				begin
					merged = lane_merge({21'h000000, start_power}, pwdata, pstrb);
					if (merged < 32'(`DPE_START_POWER_MIN))
						next_start_power = `DPE_START_POWER_MIN;
					else if (merged > 32'(`DPE_START_POWER_MAX))
						next_start_power = `DPE_START_POWER_MAX;
					else
						next_start_power = merged[10:0];
				end
				// [RULE10] angle clamp
				`DPE_ADDR_DIR_ANGLE:
				begin
					merged = lane_merge({23'h000000, dir_angle}, pwdata, pstrb);
					angle_wr = $signed(merged[8:0]);
					if (angle_wr < `DPE_ANGLE_MIN)
						next_dir_angle = `DPE_ANGLE_MIN;
					else if (angle_wr > `DPE_ANGLE_MAX)
						next_dir_angle = `DPE_ANGLE_MAX;
					else
						next_dir_angle = angle_wr;
				end
				// [RULE8] delay clamp
				`DPE_ADDR_DELAY:
				begin
					merged = lane_merge({16'h0000, delay}, pwdata, pstrb);
					if (merged < 32'(`DPE_DELAY_MIN))
						next_delay = `DPE_DELAY_MIN;
					else if (merged > 32'(`DPE_DELAY_MAX))
						next_delay = `DPE_DELAY_MAX;
					else
						next_delay = merged[15:0];
				end
				default:
				begin
					merged = 32'h00000000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic operate;
	logic [15:0] ms_cnt;

	// read data is latched in the setup cycle so it is stable in the access cycle
	always_comb
	begin
		next_prdata = prdata;
		if (psel && !penable)
		begin
			case (paddr)
				`DPE_ADDR_CTRL: next_prdata = {30'h00000000, ctrl};
				`DPE_ADDR_START_POWER: next_prdata = {21'h000000, start_power};
				`DPE_ADDR_DIR_ANGLE: next_prdata = {23'h000000, dir_angle};
				`DPE_ADDR_DELAY: next_prdata = {16'h0000, delay};
				`DPE_ADDR_STATUS: next_prdata = {27'h0000000, vt_supervision_inhibit,
					general_block, operate, general_trip_cmd, general_pickup};
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl <= `DPE_CTRL_RESET;
			start_power <= `DPE_START_POWER_RESET;
			dir_angle <= `DPE_ANGLE_RESET;
			delay <= `DPE_DELAY_RESET;
			prdata <= 32'h00000000;
		end
		else
		begin
			ctrl <= next_ctrl;
			start_power <= next_start_power;
			dir_angle <= next_dir_angle;
			delay <= next_delay;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	dpe_pkg::dpe_state_t state;
	dpe_pkg::dpe_state_t next_state;
	dpe_pkg::dpe_power_t pwr_a;
	dpe_pkg::dpe_power_t pwr_b;
	dpe_pkg::dpe_power_t pwr_c;
	dpe_pkg::dpe_power_t pq;
	dpe_pkg::dpe_power_t next_pq;
	logic phase_load;
	logic cordic_done;
	logic signed [39:0] cordic_x;
	logic signed [79:0] lhs;
	logic signed [79:0] rhs_full;
	logic signed [79:0] rhs_hyst;
	logic next_operate;

	assign meas_ready = (state == dpe_pkg::DPE_IDLE);
	assign phase_load = meas_valid && meas_ready;

	// [RULE1] per-phase power
	dpe_phase_power u_phase_a (.clk(clk), .rst_b(rst_b), .load(phase_load),
		.voltage(phase_a_voltage), .current(phase_a_current), .power(pwr_a));
	dpe_phase_power u_phase_b (.clk(clk), .rst_b(rst_b), .load(phase_load),
		.voltage(phase_b_voltage), .current(phase_b_current), .power(pwr_b));
	dpe_phase_power u_phase_c (.clk(clk), .rst_b(rst_b), .load(phase_load),
		.voltage(phase_c_voltage), .current(phase_c_current), .power(pwr_c));

	// [RULE2] projection onto direction
	dpe_cordic u_cordic (.clk(clk), .rst_b(rst_b), .start(state == dpe_pkg::DPE_START),
		.x_in(pq.p), .y_in(pq.q), .angle(dir_angle), .done(cordic_done), .x_out(cordic_x));

	// both sides scaled so the projection compares to start power with the rotation gain
	assign lhs = (80'(cordic_x) * `DPE_TENTHS_PER_UNIT * `DPE_HYST_DEN) <<< `DPE_UNIT_SHIFT;
	assign rhs_full = (80'($signed({1'b0, start_power})) * `DPE_PHASES * `DPE_CORDIC_GAIN_Q14
		* `DPE_HYST_DEN) <<< (2 * `DPE_UNIT_SHIFT);
	assign rhs_hyst = (80'($signed({1'b0, start_power})) * `DPE_PHASES * `DPE_CORDIC_GAIN_Q14
		* `DPE_HYST_NUM) <<< (2 * `DPE_UNIT_SHIFT);

	always_comb
	begin
		next_state = state;
		next_pq = pq;
		next_operate = operate;
		case (state)
			dpe_pkg::DPE_IDLE:
				if (meas_valid)
					next_state = dpe_pkg::DPE_SUM;
			// [RULE1] three-phase sum
			dpe_pkg::DPE_SUM:
			begin
				next_pq.p = pwr_a.p + pwr_b.p + pwr_c.p;
				next_pq.q = pwr_a.q + pwr_b.q + pwr_c.q;
				next_state = dpe_pkg::DPE_START;
			end
			dpe_pkg::DPE_START:
				next_state = dpe_pkg::DPE_ROT;
			dpe_pkg::DPE_ROT:
				if (cordic_done)
				begin
					// [RULE3] strict side test
					// [RULE4] hysteresis threshold
					next_operate = lhs > (operate ? rhs_hyst : rhs_full);
					next_state = dpe_pkg::DPE_IDLE;
				end
			default:
				next_state = dpe_pkg::DPE_IDLE;
		endcase
		// [RULE11] disabled clears decision
		if (!ctrl_enable)
			next_operate = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= dpe_pkg::DPE_IDLE;
			pq <= '0;
			operate <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pq <= next_pq;
			operate <= next_operate;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [31:0] prescale;
	logic [31:0] next_prescale;
	logic [15:0] next_ms_cnt;
	logic next_pickup;
	logic next_trip;

	always_comb
	begin
		// [RULE5] start gating
		// [RULE6] block disables
		next_pickup = ctrl_enable && operate && !general_block && !vt_supervision_inhibit;
		next_prescale = 32'h00000000;
		next_ms_cnt = 16'h0000;
		next_trip = 1'b0;
		// [RULE12] tick timer
		if (general_pickup)
		begin
			next_prescale = prescale + 32'h00000001;
			next_ms_cnt = ms_cnt;
			if (prescale == 32'(TICK_CYCLES) - 32'h00000001)
			begin
				next_prescale = 32'h00000000;
				if (ms_cnt != 16'hffff)
					next_ms_cnt = ms_cnt + 16'h0001;
			end
			// [RULE7] trip on expiry
			next_trip = !ctrl_start_only && (ms_cnt >= delay);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prescale <= 32'h00000000;
			ms_cnt <= 16'h0000;
			general_pickup <= 1'b0;
			general_trip_cmd <= 1'b0;
		end
		else
		begin
			prescale <= next_prescale;
			ms_cnt <= next_ms_cnt;
			general_pickup <= next_pickup;
			general_trip_cmd <= next_trip && next_pickup;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_block_stops;
		@(posedge clk) disable iff (!rst_b)
		(general_block || vt_supervision_inhibit) |=> !general_pickup && !general_trip_cmd;
	endproperty
	a_block_stops: assert property (p_block_stops) else $error("start while blocked"); // [RULE5]

	property p_general_block_hold;
		@(posedge clk) disable iff (!rst_b)
		general_block [*3] |-> !general_pickup && ms_cnt == 16'h0000;
	endproperty
	a_general_block_hold: assert property (p_general_block_hold) else $error("block ignored"); // [RULE6]

	property p_disabled_quiet;
		@(posedge clk) disable iff (!rst_b)
		!ctrl_enable |=> !operate && !general_pickup && !general_trip_cmd;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("output while off"); // [RULE11]

	property p_start_only;
		@(posedge clk) disable iff (!rst_b)
		ctrl_start_only |=> !general_trip_cmd;
	endproperty
	a_start_only: assert property (p_start_only) else $error("trip in start-only mode"); // [RULE7]

	property p_trip_cause;
		@(posedge clk) disable iff (!rst_b)
		$rose(general_trip_cmd) |-> $past(ms_cnt) >= $past(delay) && $past(general_pickup);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip before delay"); // [RULE7]

	property p_timer_clear;
		@(posedge clk) disable iff (!rst_b)
		!general_pickup |=> ms_cnt == 16'h0000 && !general_trip_cmd;
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared"); // [RULE12]

	property p_tick_step;
		@(posedge clk) disable iff (!rst_b)
		general_pickup && next_pickup && prescale == 32'(TICK_CYCLES) - 32'h00000001
			&& ms_cnt != 16'hffff |=> ms_cnt == $past(ms_cnt) + 16'h0001;
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("tick not counted"); // [RULE12]

	property p_delay_range;
		@(posedge clk) disable iff (!rst_b)
		delay >= `DPE_DELAY_MIN && delay <= `DPE_DELAY_MAX;
	endproperty
	a_delay_range: assert property (p_delay_range) else $error("delay out of range"); // [RULE8]

	property p_power_range;
		@(posedge clk) disable iff (!rst_b)
		start_power >= `DPE_START_POWER_MIN && start_power <= `DPE_START_POWER_MAX;
	endproperty
	a_power_range: assert property (p_power_range) else $error("start power out of range"); // [RULE9]

	property p_angle_range;
		@(posedge clk) disable iff (!rst_b)
		dir_angle >= `DPE_ANGLE_MIN && dir_angle <= `DPE_ANGLE_MAX;
	endproperty
	a_angle_range: assert property (p_angle_range) else $error("angle out of range"); // [RULE10]

	property p_hold_above_hyst;
		@(posedge clk) disable iff (!rst_b)
		state == dpe_pkg::DPE_ROT && cordic_done && operate && ctrl_enable && lhs > rhs_hyst
			|=> operate;
	endproperty
	a_hold_above_hyst: assert property (p_hold_above_hyst) else $error("early drop-out"); // [RULE4]

	property p_no_pick_on_line;
		@(posedge clk) disable iff (!rst_b)
		state == dpe_pkg::DPE_ROT && cordic_done && !operate && lhs <= rhs_full |=> !operate;
	endproperty
	a_no_pick_on_line: assert property (p_no_pick_on_line) else $error("pick-up on line"); // [RULE3]

	property p_decision_bound;
		@(posedge clk) disable iff (!rst_b)
		phase_load |-> ##[15:16] state == dpe_pkg::DPE_IDLE;
	endproperty
	a_decision_bound: assert property (p_decision_bound) else $error("decision late"); // [RULE1]

endmodule
`default_nettype wire

// ==== verif/dpe_meas_model.sv ====
// behavioural measurement stage offering phasor sets to the power element
`timescale 1ns/1ps
`default_nettype none
module dpe_meas_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// handshake
	input wire logic meas_ready,
	output logic meas_valid,
	// requested operating point
	input wire logic slow,
	input wire logic signed [15:0] volt,
	input wire logic signed [15:0] cur_re,
	input wire logic signed [15:0] cur_im,
	// phasors, the same on all three phases
	output dpe_pkg::dpe_phasor_t volt_ph,
	output dpe_pkg::dpe_phasor_t cur_ph
);
	logic [3:0] gap;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meas_valid <= 1'b0;
			gap <= 4'h0;
			volt_ph <= '0;
			cur_ph <= '0;
		end
		else if (meas_valid)
		begin
			if (meas_ready)
			begin
				// released lines show garbage until the next offer
				meas_valid <= 1'b0;
				gap <= slow ? 4'h9 : 4'h0;
				volt_ph <= ~volt_ph;
				cur_ph <= ~cur_ph;
			end
		end
		else if (gap != 4'h0)
		begin
			gap <= gap - 4'h1;
			volt_ph <= ~volt_ph;
			cur_ph <= ~cur_ph;
		end
		else
		begin
			meas_valid <= 1'b1;
			volt_ph <= '{re: volt, im: 16'sh0000};
			cur_ph <= '{re: cur_re, im: cur_im};
		end
	end
endmodule
`default_nettype wire

// ==== verif/dpe_directional_power_high_element_test.sv ====
// self-checking bench of the directional power element
`timescale 1ns/1ps
`default_nettype none
`include "dpe_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module dpe_directional_power_high_element_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, meas_valid, meas_ready, general_pickup, general_trip_cmd;
	logic general_block = 1'b0, vt_supervision_inhibit = 1'b0, slow = 1'b0;
	logic signed [15:0] cur_re = 16'sh0000, cur_im = 16'sh0000;
	dpe_pkg::dpe_phasor_t vph, iph;
	int n_errors = 0, n_checks = 0, cycles = 0;
	logic [31:0] rd;
	logic er;

	always #2.5 clk = ~clk;

	dpe_directional_power_high_element #(.TICK_CYCLES(4)) i_dut (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_valid(meas_valid), .meas_ready(meas_ready), .phase_a_voltage(vph),
		.phase_b_voltage(vph), .phase_c_voltage(vph), .phase_a_current(iph),
		.phase_b_current(iph), .phase_c_current(iph), .general_block(general_block),
		.vt_supervision_inhibit(vt_supervision_inhibit), .general_pickup(general_pickup),
		.general_trip_cmd(general_trip_cmd));

	dpe_meas_model i_src (.clk(clk), .rst_b(rst_b), .meas_ready(meas_ready),
		.meas_valid(meas_valid), .slow(slow), .volt(16'sh4000), .cur_re(cur_re),
		.cur_im(cur_im), .volt_ph(vph), .cur_ph(iph));

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// pready is tied high in the element, so this wait ends at once
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// 16384 on current is 1.0 pu, so 3277 is 20 percent of nominal power
	task automatic pwr(input logic signed [15:0] r, input logic signed [15:0] i);
		@(posedge clk);
		cur_re <= r;
		cur_im <= i;
	endtask

	task automatic wpk(input logic e, input int n);
		int k;
		k = 0;
		while (general_pickup !== e && k < n)
		begin
			@(negedge clk);
			k++;
		end
	endtask

	task automatic settle();
		repeat (60) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [11:0] ad[6] = '{`DPE_ADDR_START_POWER, `DPE_ADDR_START_POWER,
			`DPE_ADDR_DELAY, `DPE_ADDR_DELAY, `DPE_ADDR_DIR_ANGLE, `DPE_ADDR_DIR_ANGLE};
		logic [31:0] wd[6] = '{32'h0, 32'hfff, 32'h0, 32'hffff, 32'h138, 32'h0c8};
		logic [31:0] ex[6] = '{32'h00a, 32'h7d0, 32'h0c8, 32'hea60, 32'h14d, 32'h0b4};
		apb(1'b0, `DPE_ADDR_CTRL, 32'h0);
		`CHK({pready, rd}, {1'b1, 32'h0})
		apb(1'b0, `DPE_ADDR_START_POWER, 32'h0);
		`CHK(rd, 32'h64)
		apb(1'b0, `DPE_ADDR_DIR_ANGLE, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, `DPE_ADDR_DELAY, 32'h0);
		`CHK(rd, 32'hc8)
		apb(1'b0, 12'h020, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, `DPE_ADDR_STATUS, 32'hffffffff);
		`CHK(er, 1'b1)
		for (int j = 0; j < 6; j++)
		begin
			apb(1'b1, ad[j], wd[j]);
			apb(1'b0, ad[j], 32'h0);
			`CHK(rd, ex[j])
		end
		apb(1'b1, `DPE_ADDR_START_POWER, 32'h64);
		apb(1'b1, `DPE_ADDR_DELAY, 32'hc8);
		apb(1'b1, `DPE_ADDR_DIR_ANGLE, 32'h0);
	endtask

	// a taken phasor set keeps the element busy for 15 cycles
	task automatic t_meas();
		int k;
		k = 0;
		@(posedge clk iff (meas_valid && meas_ready));
		@(negedge clk);
		while (meas_ready !== 1'b1 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
		`CHK(k, 15)
	endtask

	task automatic t_dir();
		logic [8:0] an[6] = '{9'h000, 9'h000, 9'h05a, 9'h05a, 9'h1a6, 9'h0b4};
		logic signed [15:0] re[6] = '{16'sh0ccd, 16'shf333, 16'sh0ccd, 0, 0, 16'shf333};
		logic signed [15:0] im[6] = '{0, 0, 0, 16'shf333, 16'shf333, 0};
		logic ep[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		pwr(16'sh0ccd, 16'sh0000);
		settle();
		`CHK(general_pickup, 1'b0)
		apb(1'b1, `DPE_ADDR_CTRL, 32'h1);
		for (int j = 0; j < 6; j++)
		begin
			apb(1'b1, `DPE_ADDR_DIR_ANGLE, {23'h0, an[j]});
			pwr(re[j], im[j]);
			settle();
			`CHK(general_pickup, ep[j])
		end
		apb(1'b1, `DPE_ADDR_DIR_ANGLE, 32'h0);
		pwr(16'sh0000, 16'sh0000);
		settle();
	endtask

	task automatic t_trip();
		int k;
		slow <= 1'b1;
		pwr(16'sh0ccd, 16'sh0000);
		wpk(1'b1, 80);
		`CHK(general_pickup, 1'b1)
		k = 0;
		while (general_trip_cmd !== 1'b1 && k < 2000)
		begin
			@(negedge clk);
			k++;
		end
		`CHK(k >= 790 && k <= 810, 1'b1)
		pwr(16'sh0635, 16'sh0000);
		settle();
		`CHK({general_pickup, general_trip_cmd}, 2'b11)
		// status shows pickup, trip and the held directional decision
		apb(1'b0, `DPE_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h00000007)
		pwr(16'sh0333, 16'sh0000);
		wpk(1'b0, 80);
		`CHK(general_pickup, 1'b0)
		repeat (2) @(negedge clk);
		`CHK(general_trip_cmd, 1'b0)
		slow <= 1'b0;
	endtask

	task automatic t_block();
		pwr(16'sh0ccd, 16'sh0000);
		wpk(1'b1, 60);
		@(posedge clk);
		general_block <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK({general_pickup, general_trip_cmd}, 2'b00)
		@(posedge clk);
		general_block <= 1'b0;
		wpk(1'b1, 60);
		`CHK(general_pickup, 1'b1)
		@(posedge clk);
		vt_supervision_inhibit <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK(general_pickup, 1'b0)
		@(posedge clk);
		vt_supervision_inhibit <= 1'b0;
		pwr(16'sh0000, 16'sh0000);
		settle();
	endtask

	task automatic t_sonly();
		apb(1'b1, `DPE_ADDR_CTRL, 32'h3);
		pwr(16'sh0ccd, 16'sh0000);
		wpk(1'b1, 60);
		`CHK(general_pickup, 1'b1)
		repeat (1000) @(negedge clk);
		`CHK(general_trip_cmd, 1'b0)
		pwr(16'sh0000, 16'sh0000);
		wpk(1'b0, 60);
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_meas();
		t_dir();
		t_trip();
		t_block();
		t_sonly();
		end_of_test();
	end
endmodule
`default_nettype wire
